// ==== verilog/axis_fifo_pkg.sv ====
// Package with the constants, register map and mode codes of the fall-through FIFO.
package axis_fifo_pkg;

  // ---------------------------------------------------------------------------
  // Depth limits and default depths
  // ---------------------------------------------------------------------------
  localparam int DEPTH_MIN     = 16;
  localparam int DEPTH_MAX     = 4194304;
  localparam int DEPTH_BLOCK   = 1024;
  localparam int DEPTH_DISTRIB = 16;

  // ---------------------------------------------------------------------------
  // Ready and valid generation modes
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RDY_FULL   = 2'b00,
    RDY_AFULL  = 2'b01,
    RDY_PFULL  = 2'b10
  } ready_mode_t;

  typedef enum logic [1:0] {
    VLD_EMPTY  = 2'b00,
    VLD_AEMPTY = 2'b01,
    VLD_PEMPTY = 2'b10
  } valid_mode_t;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_STICKY = 12'h008;

  localparam int CTRL_INJ_SBIT = 0;
  localparam int CTRL_INJ_DBIT = 1;

  localparam int STAT_FULL   = 24;
  localparam int STAT_EMPTY  = 25;
  localparam int STAT_AFULL  = 26;
  localparam int STAT_AEMPTY = 27;
  localparam int STAT_PFULL  = 28;
  localparam int STAT_PEMPTY = 29;

  localparam int STK_OVF  = 0;
  localparam int STK_UDF  = 1;
  localparam int STK_SBIT = 2;
  localparam int STK_DBIT = 3;

  localparam logic [1:0]  CTRL_RST   = 2'h0;
  localparam logic [3:0]  STICKY_RST = 4'h0;
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

endpackage : axis_fifo_pkg

// ==== verilog/axis_fwft_fifo.sv ====
// Single-clock first-word fall-through FIFO for an AXI4-Stream channel with an APB port.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Oldest word appears at the read side without any read request.
// - Write ready follows full, almost-full or programmable-full by configuration.
// - Read valid follows empty, almost-empty or programmable-empty by configuration.
// - Depth is a power of two from 16 up to 4194304 words.
// - Occupancy count is log2 of depth plus one bit wide.
// - One shared clock, so a single occupancy count is given.
// - Read on empty raises the read error flag and changes nothing.
// - Write on full raises the write error flag and is discarded.
// - Default depth 1024 for stream data, 16 for small channels.
// - Write and read words have the same width.
// - Each entry carries all selected channel signals together.
// - Optional error correction with single and double bit injection.
// - The asynchronous clear resets all control state but not the storage array; all else is clocked.
// - Requests and words are sampled on the clock; status used locally.
// - Everything is evaluated on the rising clock edge.
// - Domain crossing handled internally; trivial with one clock.
// - A written word takes cycles before it is seen at the output.
// - Programmable full asserts once occupancy reaches its threshold.
// - Programmable empty asserts once occupancy falls to its threshold.
// - Count rises on accepted writes and falls on accepted reads.
// - Error flags are optional outputs.
module axis_fwft_fifo #(
  parameter int                       DEPTH      = axis_fifo_pkg::DEPTH_BLOCK,
  parameter int                       DATA_W     = 64,
  parameter int                       USER_W     = 1,
  parameter axis_fifo_pkg::ready_mode_t READY_MODE = axis_fifo_pkg::RDY_FULL,
  parameter axis_fifo_pkg::valid_mode_t VALID_MODE = axis_fifo_pkg::VLD_EMPTY,
  parameter int                       PF_THRESH  = 1000,
  parameter int                       PE_THRESH  = 2,
  parameter bit                       ECC_EN     = 1'b1,
  parameter bit                       ERR_EN     = 1'b1,
  parameter bit                       OVF_HIGH   = 1'b1,
  parameter bit                       UDF_HIGH   = 1'b1,
  parameter int                       CW         = $clog2(DEPTH) + 1
) (
  input  wire logic              core_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              s_tvalid_in,
  output logic                   s_tready_out,
  input  wire logic [DATA_W-1:0] s_tdata_in,
  input  wire logic [USER_W-1:0] s_tuser_in,
  input  wire logic              s_tlast_in,
  output logic                   m_tvalid_out,
  input  wire logic              m_tready_in,
  output logic [DATA_W-1:0]      m_tdata_out,
  output logic [USER_W-1:0]      m_tuser_out,
  output logic                   m_tlast_out,
  output logic [CW-1:0]          count_out,
  output logic                   full_out,
  output logic                   empty_out,
  output logic                   prog_full_out,
  output logic                   prog_empty_out,
  output logic                   overflow_out,
  output logic                   underflow_out,
  output logic                   sbiterr_out,
  output logic                   dbiterr_out,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [11:0]       paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out
);
  import axis_fifo_pkg::*;

  // ---------------------------------------------------------------------------
  // Storage layout
  // ---------------------------------------------------------------------------
  localparam int AW     = $clog2(DEPTH);
  localparam int WORD_W = DATA_W + USER_W + 1;
  // Two parity-guarded copies per entry: cheap to decode at any width, at the
  // cost of doubling the storage flops.
  localparam int MEM_W  = 2 * WORD_W + 2;
  localparam logic [CW-1:0] CNT_DEPTH = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_AFULL = CW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_PF    = CW'(PF_THRESH);
  localparam logic [CW-1:0] CNT_PE    = CW'(PE_THRESH);
  localparam logic [CW-1:0] CNT_ONE   = CW'(1);
  localparam logic          OVF_IDLE  = !OVF_HIGH;
  localparam logic          UDF_IDLE  = !UDF_HIGH;

  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  logic [MEM_W-1:0]  mem_ff [DEPTH];
  logic [AW-1:0]     wr_ptr_ff;
  logic [AW-1:0]     rd_ptr_ff;
  logic [CW-1:0]     count_ff;
  logic              out_valid_ff;
  logic [WORD_W-1:0] out_word_ff;
  logic              sbit_ff;
  logic              dbit_ff;
  logic              ready_ff;
  logic              valid_ff;
  logic              empty_ff;
  logic              full_ff;
  logic              pfull_ff;
  logic              pempty_ff;
  logic              ovf_ff;
  logic              udf_ff;
  logic [1:0]        ctrl_ff;
  logic [3:0]        sticky_ff;
  logic              pready_ff;
  logic [31:0]       prdata_ff;
  logic              pslverr_ff;

  // ---------------------------------------------------------------------------
  // Transfer decode
  // ---------------------------------------------------------------------------
  // writer gated by ready
  wire               wr_acc   = s_tvalid_in && ready_ff && !full_ff;
  wire               rd_acc   = valid_ff && m_tready_in;
  wire  [CW-1:0]     mem_cnt  = count_ff - CW'(out_valid_ff);
  wire               load_out = (!out_valid_ff || rd_acc) && (mem_cnt != '0);
  wire  [CW-1:0]     nxt_count = count_ff + CW'(wr_acc) - CW'(rd_acc);
  wire               nxt_out_valid = load_out || (out_valid_ff && !rd_acc);

  // write on full is an error
  wire               ovf_event = s_tvalid_in && full_ff;
  // read on empty is an error
  // A word still falling through is not an underflow, so only a drained FIFO counts.
  wire               udf_event = m_tready_in && (count_ff == '0);

  wire               nxt_full   = (nxt_count == CNT_DEPTH);
  wire               nxt_afull  = (nxt_count >= CNT_AFULL);
  wire               nxt_pfull  = (nxt_count >= CNT_PF);
  wire               nxt_aempty = (nxt_count <= CNT_ONE);
  wire               nxt_pempty = (nxt_count <= CNT_PE);

  // ready from the selected full flag
  wire               nxt_ready = (READY_MODE == RDY_AFULL) ? !nxt_afull :
                                 (READY_MODE == RDY_PFULL) ? !nxt_pfull : !nxt_full;
  // valid from the selected empty flag
  wire               nxt_valid = nxt_out_valid &&
                                 ((VALID_MODE == VLD_AEMPTY) ? !nxt_aempty :
                                  (VALID_MODE == VLD_PEMPTY) ? !nxt_pempty : 1'b1);

  // ---------------------------------------------------------------------------
  // Error correction encode and decode
  // ---------------------------------------------------------------------------
  // all channel signals travel in one entry
  wire  [WORD_W-1:0] wr_word  = {s_tlast_in, s_tuser_in, s_tdata_in};
  // injection flips bits after parity is taken
  wire               inj_a    = ECC_EN && (ctrl_ff[CTRL_INJ_SBIT] || ctrl_ff[CTRL_INJ_DBIT]);
  wire               inj_b    = ECC_EN && ctrl_ff[CTRL_INJ_DBIT];
  wire  [WORD_W-1:0] copy_a   = wr_word ^ WORD_W'(inj_a);
  wire  [WORD_W-1:0] copy_b   = wr_word ^ WORD_W'(inj_b);
  wire  [MEM_W-1:0]  wr_entry = {^wr_word, copy_b, ^wr_word, copy_a};

  wire  [MEM_W-1:0]  rd_entry = mem_ff[rd_ptr_ff];
  wire  [WORD_W-1:0] rd_a     = rd_entry[WORD_W-1:0];
  wire  [WORD_W-1:0] rd_b     = rd_entry[2*WORD_W:WORD_W+1];
  wire               a_ok     = !ECC_EN || ((^rd_a) == rd_entry[WORD_W]);
  wire               b_ok     = (^rd_b) == rd_entry[MEM_W-1];
  // one bad copy is corrected, two are reported
  wire  [WORD_W-1:0] rd_word  = a_ok ? rd_a : rd_b;
  wire               rd_sbit  = !a_ok && b_ok;
  wire               rd_dbit  = !a_ok && !b_ok;

  // ---------------------------------------------------------------------------
  // Storage and pointers
  // ---------------------------------------------------------------------------
  // one width on both sides
  always_ff @(posedge core_clk_in) begin
    if (wr_acc) begin
      mem_ff[wr_ptr_ff] <= wr_entry;
    end
  end

  // asynchronous clear of all control state
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
      count_ff     <= '0;
      out_valid_ff <= 1'b0;
    end else begin
      wr_ptr_ff    <= wr_acc ? wr_ptr_ff + AW'(1) : wr_ptr_ff;
      rd_ptr_ff    <= load_out ? rd_ptr_ff + AW'(1) : rd_ptr_ff;
      count_ff     <= nxt_count;
      out_valid_ff <= nxt_out_valid;
    end
  end

  // output stage adds one cycle after storage
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_word_ff <= '0;
      sbit_ff     <= 1'b0;
      dbit_ff     <= 1'b0;
    end else if (load_out) begin
      out_word_ff <= rd_word;
      sbit_ff     <= rd_sbit;
      dbit_ff     <= rd_dbit;
    end
  end

  // ---------------------------------------------------------------------------
  // Flags and error outputs
  // ---------------------------------------------------------------------------
  // status registered in the one clock domain
  // a single domain needs no crossing logic
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ready_ff  <= 1'b0;
      valid_ff  <= 1'b0;
      empty_ff  <= 1'b1;
      full_ff   <= 1'b0;
      pfull_ff  <= 1'b0;
      pempty_ff <= 1'b1;
      ovf_ff    <= OVF_IDLE;
      udf_ff    <= UDF_IDLE;
    end else begin
      ready_ff  <= nxt_ready;
      valid_ff  <= nxt_valid;
      empty_ff  <= !nxt_valid;
      full_ff   <= nxt_full;
      pfull_ff  <= nxt_pfull;
      pempty_ff <= nxt_pempty;
      // flags held idle when not built
      ovf_ff    <= (ERR_EN && ovf_event) ? OVF_HIGH : OVF_IDLE;
      udf_ff    <= (ERR_EN && udf_event) ? UDF_HIGH : UDF_IDLE;
    end
  end

  // ---------------------------------------------------------------------------
  // APB register port
  // ---------------------------------------------------------------------------
  wire        apb_done  = psel_in && penable_in && pready_ff;
  wire        hit_ctrl  = reg_hit(paddr_in, OFS_CTRL);
  wire        hit_stat  = reg_hit(paddr_in, OFS_STATUS);
  wire        hit_stk   = reg_hit(paddr_in, OFS_STICKY);
  wire        unmapped  = !(hit_ctrl || hit_stat || hit_stk);
  wire        wr_ctrl   = apb_done && pwrite_in && hit_ctrl;
  wire        wr_stk    = apb_done && pwrite_in && hit_stk;
  wire [3:0]  stk_set   = {rd_dbit && load_out, rd_sbit && load_out, udf_event, ovf_event};
  wire [31:0] status_w  = {2'b00, pempty_ff, pfull_ff, (count_ff <= CNT_ONE),
                           !ready_ff, !out_valid_ff, full_ff, 24'(count_ff)};
  wire [31:0] rd_mux    = hit_ctrl ? {30'h0, ctrl_ff} :
                          hit_stat ? status_w :
                          hit_stk  ? {28'h0, sticky_ff} : 32'h0;
  // Injection is one-shot: it is spent by the next accepted write.
  wire [1:0]  nxt_ctrl  = wr_ctrl ? pwdata_in[1:0] : (wr_acc ? 2'b00 : ctrl_ff);
  // Set wins over a write-one-to-clear in the same cycle.
  wire [3:0]  nxt_stk   = (sticky_ff & ~(wr_stk ? pwdata_in[3:0] : 4'h0)) | stk_set;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_ff    <= CTRL_RST;
      sticky_ff  <= STICKY_RST;
      pready_ff  <= 1'b0;
      prdata_ff  <= PRDATA_RST;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      sticky_ff  <= nxt_stk;
      pready_ff  <= psel_in && penable_in && !pready_ff;
      prdata_ff  <= (psel_in && penable_in && !pready_ff && !pwrite_in) ? rd_mux : PRDATA_RST;
      pslverr_ff <= psel_in && penable_in && !pready_ff && unmapped;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // one occupancy count for the shared clock
  // count width is log2 depth plus one
  assign count_out      = count_ff;
  assign s_tready_out   = ready_ff;
  assign m_tvalid_out   = valid_ff;
  assign m_tdata_out    = out_word_ff[DATA_W-1:0];
  assign m_tuser_out    = out_word_ff[DATA_W+USER_W-1:DATA_W];
  assign m_tlast_out    = out_word_ff[WORD_W-1];
  assign full_out       = full_ff;
  assign empty_out      = empty_ff;
  assign prog_full_out  = pfull_ff;
  assign prog_empty_out = pempty_ff;
  assign overflow_out   = ovf_ff;
  assign underflow_out  = udf_ff;
  assign sbiterr_out    = sbit_ff;
  assign dbiterr_out    = dbit_ff;
  assign prdata_out     = prdata_ff;
  assign pready_out     = pready_ff;
  assign pslverr_out    = pslverr_ff;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  initial begin : chk_depth_range
    assert ((DEPTH >= DEPTH_MIN) && (DEPTH <= DEPTH_MAX) && ((DEPTH & (DEPTH - 1)) == 0))
      else $error("FIFO depth is not a power of two within range.");
  end

  chk_ready_when_full: assert property (full_ff |-> !s_tready_out)
    else $error("Ready high while full.");

  chk_count_tracks: assert property (##1 count_ff == $past(count_ff) + CW'($past(wr_acc))
                                     - CW'($past(rd_acc)))
    else $error("Count does not follow accepted transfers.");

  chk_overflow_flag: assert property (ERR_EN && ovf_event |=>
                                      overflow_out == OVF_HIGH && count_ff == $past(count_ff)
                                      - CW'($past(rd_acc)))
    else $error("Overflow not flagged or write not discarded.");

  chk_underflow_flag: assert property (ERR_EN && udf_event |=>
                                       underflow_out == UDF_HIGH && $stable(rd_ptr_ff))
    else $error("Underflow not flagged or state changed.");

  chk_fall_through: assert property (!out_valid_ff && mem_cnt != '0 |=> out_valid_ff)
    else $error("Stored word did not fall through.");

  chk_write_latency: assert property (wr_acc && count_ff == '0 |-> ##2 out_valid_ff)
    else $error("First word not at output two cycles after write.");

  chk_valid_source: assert property (m_tvalid_out |-> out_valid_ff && count_ff != '0)
    else $error("Valid without a held word.");

  chk_pfull_level: assert property (count_ff >= CNT_PF |-> prog_full_out)
    else $error("Programmable full missing at threshold.");

  chk_pempty_level: assert property (count_ff <= CNT_PE |-> prog_empty_out)
    else $error("Programmable empty missing at threshold.");

  chk_apb_answer: assert property (psel_in && penable_in && !pready_ff |=> pready_out)
    else $error("APB access not answered in one cycle.");

  chk_sticky_ecc: assert property (load_out && rd_sbit |=> sticky_ff[STK_SBIT])
    else $error("Corrected word did not set its sticky bit.");

  chk_ctrl_oneshot: assert property (wr_acc && !wr_ctrl |=> ctrl_ff == 2'b00)
    else $error("Injection request not spent by the accepted write.");

  chk_overflow_idle: assert property (!(ERR_EN && ovf_event) |=> overflow_out == OVF_IDLE)
    else $error("Overflow flag not at its idle level.");

  chk_underflow_idle: assert property (!(ERR_EN && udf_event) |=> underflow_out == UDF_IDLE)
    else $error("Underflow flag not at its idle level.");

  chk_empty_count: assert property (count_ff == '0 |-> empty_out)
    else $error("Empty flag low with nothing stored.");

  chk_no_write_full: assert property (full_ff |=> $stable(wr_ptr_ff))
    else $error("Write pointer moved while full.");

  cov_fill_full:  cover property (full_ff ##1 ovf_event);
  cov_read_empty: cover property (rd_acc ##1 !out_valid_ff);
  cov_both_xfer:  cover property (wr_acc && rd_acc);
  cov_ecc_fix:    cover property (load_out && rd_sbit);

endmodule : axis_fwft_fifo

`default_nettype wire

// ==== verif/axis_stream_partner.sv ====
// Behavioural stream writer and reader that face the FIFO's two channels.
`timescale 1ns/100ps
`default_nettype none
module axis_stream_partner (
  input  wire logic        clk_in,
  input  wire logic        s_tready_in,
  input  wire logic        m_tvalid_in,
  input  wire logic [63:0] m_tdata_in,
  input  wire logic        m_tuser_in,
  input  wire logic        m_tlast_in,
  output logic             s_tvalid_out,
  output logic [65:0]      s_word_out,
  output logic             m_tready_out
);
  initial begin
    s_tvalid_out = 1'b0;
    s_word_out = 66'h0;
    m_tready_out = 1'b0;
  end
  task automatic push(input logic [65:0] w);
    s_tvalid_out <= 1'b1;
    s_word_out <= w;
    do @(posedge clk_in); while (s_tready_in !== 1'b1);
  endtask : push
  // Released lines show the inverse, so a stale word never passes for a fresh one.
  task automatic src_idle();
    s_tvalid_out <= 1'b0;
    s_word_out <= ~s_word_out;
  endtask : src_idle
  task automatic force_write();
    s_tvalid_out <= 1'b1;
    @(posedge clk_in);
    s_tvalid_out <= 1'b0;
  endtask : force_write
  // Reader takes a word on valid.
  task automatic pop(output logic [65:0] w);
    m_tready_out <= 1'b1;
    do @(posedge clk_in); while (m_tvalid_in !== 1'b1);
    w = {m_tlast_in, m_tuser_in, m_tdata_in};
  endtask : pop
  task automatic sink_idle();
    m_tready_out <= 1'b0;
  endtask : sink_idle
  task automatic poke_read();
    m_tready_out <= 1'b1;
    @(posedge clk_in);
    m_tready_out <= 1'b0;
  endtask : poke_read
endmodule : axis_stream_partner
`default_nettype wire

// ==== verif/tb_axis_fwft_fifo.sv ====
// Self-checking bench for the fall-through FIFO and its register port.
`timescale 1ns/100ps
`default_nettype none
module tb_axis_fwft_fifo;
  import axis_fifo_pkg::*;
  localparam int DEPTH = 16;
  localparam int PF    = 12;
  localparam int PE    = 2;
  localparam int CW    = $clog2(DEPTH) + 1;
  logic          core_clk_in = 1'b0;
  logic          sys_rst_in  = 1'b1;
  logic          s_tvalid, s_tready, m_tvalid, m_tready, m_tuser, m_tlast;
  logic [65:0]   s_word, w, e;
  logic [63:0]   m_tdata;
  logic [CW-1:0] count;
  logic          full, empty, pfull, pempty, ovf, udf, sbit, dbit, seen;
  logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, q_err;
  logic [11:0]   paddr  = 12'h000;
  logic [31:0]   pwdata = 32'h0, prdata, q;
  int            err_count = 0, tests_run = 0, cycles = 0;

  always #12.5 core_clk_in = ~core_clk_in;

  axis_fwft_fifo #(.DEPTH(DEPTH), .PF_THRESH(PF), .PE_THRESH(PE)) i_dut (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .s_tvalid_in(s_tvalid), .s_tready_out(s_tready), .s_tdata_in(s_word[63:0]),
    .s_tuser_in(s_word[64]), .s_tlast_in(s_word[65]), .m_tvalid_out(m_tvalid),
    .m_tready_in(m_tready), .m_tdata_out(m_tdata), .m_tuser_out(m_tuser),
    .m_tlast_out(m_tlast), .count_out(count), .full_out(full), .empty_out(empty),
    .prog_full_out(pfull), .prog_empty_out(pempty), .overflow_out(ovf),
    .underflow_out(udf), .sbiterr_out(sbit), .dbiterr_out(dbit), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));

  axis_stream_partner i_far (
    .clk_in(core_clk_in), .s_tready_in(s_tready), .m_tvalid_in(m_tvalid),
    .m_tdata_in(m_tdata), .m_tuser_in(m_tuser), .m_tlast_in(m_tlast),
    .s_tvalid_out(s_tvalid), .s_word_out(s_word), .m_tready_out(m_tready));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk_word(input string n, input logic [63:0] x, input logic [63:0] g);
    tests_run++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", n, x, g);
      err_count++;
    end
  endtask : chk_word

  task automatic chk_flag(input string n, input logic x, input logic g);
    tests_run++;
    if (g !== x) begin
      $display("[ERR] %s expected %b seen %b", n, x, g);
      err_count++;
    end
  endtask : chk_flag

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    do @(posedge core_clk_in); while (pready !== 1'b1);
    q = prdata;
    q_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg_chk(input string n, input logic [11:0] a, input logic [31:0] x,
                         input logic xe);
    apb(1'b0, a, 32'h0);
    chk_word(n, {32'h0, x}, {32'h0, q});
    chk_flag(n, xe, q_err);
  endtask : reg_chk

  task automatic settle();
    repeat (2) @(posedge core_clk_in);
    #1;
  endtask : settle

  // Flag is a one-cycle pulse, so it is looked for over two cycles.
  task automatic pulse_seen(input bit use_ovf);
    seen = 1'b0;
    repeat (2) begin
      #1 seen = seen | ((use_ovf ? ovf : udf) === 1'b1);
      @(posedge core_clk_in);
    end
  endtask : pulse_seen

  function automatic logic [65:0] word(input int i);
    return {1'(i == DEPTH - 1), 1'(i % 2), 64'h0123_4567_89ab_cd00 + 64'(i)};
  endfunction : word

  // ---------------------------------------------------------------------------
  // Timeout and main sequence
  // ---------------------------------------------------------------------------
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    repeat (19) @(posedge core_clk_in);
    #1 chk_flag("ready_rst", 1'b0, s_tready);
    chk_flag("empty_rst", 1'b1, empty);
    chk_word("count_rst", 64'h0, 64'(count));
    @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    reg_chk("status_idle", OFS_STATUS, 32'h2a00_0000, 1'b0);
    reg_chk("unmapped", 12'h00c, 32'h0, 1'b1);
    for (int i = 0; i < DEPTH; i++) begin
      if (i == PF - 1 || i == PF) begin
        i_far.src_idle();
        settle();
        chk_flag("prog_full", 1'(i == PF), pfull);
      end
      i_far.push(word(i));
      #1 chk_word("count_fill", 64'(i + 1), 64'(count));
    end
    i_far.src_idle();
    settle();
    chk_flag("ready_full", 1'b0, s_tready);
    chk_flag("full", 1'b1, full);
    chk_word("count_full", 64'(DEPTH), 64'(count));
    reg_chk("status_full", OFS_STATUS, 32'h1500_0010, 1'b0);
    i_far.force_write();
    pulse_seen(1'b1);
    chk_flag("overflow", 1'b1, seen);
    chk_word("count_ovf", 64'(DEPTH), 64'(count));
    reg_chk("sticky_ovf", OFS_STICKY, 32'h1, 1'b0);
    apb(1'b1, OFS_STICKY, 32'h1);
    reg_chk("sticky_clr", OFS_STICKY, 32'h0, 1'b0);
    for (int i = 0; i < DEPTH; i++) begin
      if (i == DEPTH - PE - 1 || i == DEPTH - PE) begin
        i_far.sink_idle();
        settle();
        chk_flag("prog_empty", 1'(i == DEPTH - PE), pempty);
      end
      e = word(i);
      i_far.pop(w);
      chk_word("data", e[63:0], w[63:0]);
      chk_word("user_last", 64'(e[65:64]), 64'(w[65:64]));
    end
    i_far.sink_idle();
    settle();
    i_far.poke_read();
    pulse_seen(1'b0);
    chk_flag("underflow", 1'b1, seen);
    chk_word("count_udf", 64'h0, 64'(count));
    chk_flag("empty_udf", 1'b1, empty);
    reg_chk("sticky_udf", OFS_STICKY, 32'h2, 1'b0);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFS_CTRL, 32'(k + 1));
      e = word(20 + k);
      i_far.push(e);
      i_far.src_idle();
      repeat (3) @(posedge core_clk_in);
      #1 chk_flag("fall_through", 1'b1, m_tvalid);
      chk_word("ecc_data", e[63:0] ^ 64'(k), m_tdata);
      chk_flag("sbiterr", 1'(k == 0), sbit);
      chk_flag("dbiterr", 1'(k == 1), dbit);
      i_far.pop(w);
      i_far.sink_idle();
    end
    reg_chk("sticky_ecc", OFS_STICKY, 32'he, 1'b0);
    stop_test();
  end
endmodule : tb_axis_fwft_fifo
`default_nettype wire
